// *** hdl/ccu_consts.vh ***
// constants for the two-unit capture/compare block
// Operation
// - holding value split into low and high bytes
// - mode 0000 disables unit, resets its state
// - modes 0100-0111 pick capture edge and prescale
// - 1000/1001 drive pin high/low, set flag
// - 1010 sets flag only, pin untouched
// - 1011 sets flag and fires special trigger
// - 11xx is pwm class; it only enables the pin driver, bits 5-4 are stored but unused
// - control bits 7-6 always read zero
// - capture copies timer-1 count into holding value
// - capture sets flag; only software clears it
// - new capture overwrites unread holding value
// - port write on output pin may capture
// - mode change may raise false flag
// - prescaler cleared when off or not capturing
// - prescale switch keeps counter, may raise flag
// - compare equality sets pin action and flag together
// - both units identical except trigger's conversion start
// - both units share one timer-1 time base
// - clearing control forces output latch low
// - trigger reset never sets timer-1 overflow flag
// - timer-1 write beats coincident trigger reset
`ifndef CCU_CONSTS_VH
`define CCU_CONSTS_VH
// register indices; byte address is four times the index
`define CCU_IDX_FLAGS_1 10'h00c
`define CCU_IDX_FLAGS_2 10'h00d
`define CCU_IDX_U1_LOW 10'h015
`define CCU_IDX_U1_HIGH 10'h016
`define CCU_IDX_U1_CTRL 10'h017
`define CCU_IDX_U2_LOW 10'h01b
`define CCU_IDX_U2_HIGH 10'h01c
`define CCU_IDX_U2_CTRL 10'h01d
`define CCU_IDX_ENABLE_1 10'h08c
`define CCU_IDX_ENABLE_2 10'h08d
// flag bit positions
`define CCU_U1_FLAG_BIT 2
`define CCU_U2_FLAG_BIT 0
// control field layout
`define CCU_CTRL_IMPL_W 6
`define CCU_MODE_CLASS_CAPTURE 2'h1
`define CCU_MODE_CLASS_COMPARE 2'h2
`define CCU_MODE_CLASS_PWM 2'h3
`define CCU_MODE_OFF 4'h0
`define CCU_CAP_FALL 2'h0
`define CCU_CAP_RISE 2'h1
`define CCU_CAP_RISE4 2'h2
`define CCU_CAP_RISE16 2'h3
`define CCU_CMP_SET 2'h0
`define CCU_CMP_CLEAR 2'h1
`define CCU_CMP_SOFT 2'h2
`define CCU_CMP_TRIGGER 2'h3
`define CCU_PSC_LAST4 2'h3
`define CCU_PSC_LAST16 4'hf
// reset values
`define CCU_RST_BYTE 8'h00
`define CCU_RST_CTRL 6'h00
`define CCU_RST_HOLD 16'h0000
// bus answers
`define CCU_RESP_OKAY 2'h0
`define CCU_RESP_SLVERR 2'h2
`endif

// *** hdl/ccu_top.v ***
// two capture/compare units behind an axi4-lite register slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ccu_consts.vh"
module ccu_top
(
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [15:0] timer_one_count,
   input wire timer_one_write,
   input wire adc_enabled,
   input wire [1:0] port_c_direction,
   input wire [1:0] event_pin_in,
   output reg [1:0] event_pin_out,
   output reg [1:0] event_pin_oe,
   output reg timer_one_reset,
   output reg adc_start
);

   // ****************************************
   // write channel
   // ****************************************
   reg aw_held;
   reg w_held;
   reg [9:0] aw_idx;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire wr_go;
   wire wr_byte;
   reg wr_hit;

   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign wr_byte = wr_go && w_strb[0];

   always @*
   begin
      case (aw_idx)
         `CCU_IDX_FLAGS_1, `CCU_IDX_FLAGS_2, `CCU_IDX_U1_LOW, `CCU_IDX_U1_HIGH,
         `CCU_IDX_U1_CTRL, `CCU_IDX_U2_LOW, `CCU_IDX_U2_HIGH, `CCU_IDX_U2_CTRL,
         `CCU_IDX_ENABLE_1, `CCU_IDX_ENABLE_2:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 10'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CCU_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[11:2];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // enable registers (stored and read back)
   // ****************************************
   reg [7:0] irq_enable_1;
   reg irq_enable_2;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_enable_1 <= `CCU_RST_BYTE;
         irq_enable_2 <= 1'b0;
      end
      else
      begin
         if (wr_byte && aw_idx == `CCU_IDX_ENABLE_1)
            irq_enable_1 <= w_data[7:0];
         if (wr_byte && aw_idx == `CCU_IDX_ENABLE_2)
            irq_enable_2 <= w_data[0];
      end
   end

   // ****************************************
   // capture/compare units
   // ****************************************
   reg [1:0] sync_a;
   reg [1:0] sync_b;
   reg [1:0] sync_c;
   reg [1:0] pin_level;
   reg [1:0] match_prev;
   reg [1:0] flag;
   reg [1:0] trig;
   reg [31:0] hold_flat;
   reg [11:0] ctrl_flat;
   reg [7:0] psc_flat;

   genvar u;
   generate
      for (u = 0; u < 2; u = u + 1)
      begin : g_unit
         wire [9:0] idx_low = (u == 0) ? `CCU_IDX_U1_LOW : `CCU_IDX_U2_LOW;
         wire [9:0] idx_high = (u == 0) ? `CCU_IDX_U1_HIGH : `CCU_IDX_U2_HIGH;
         wire [9:0] idx_ctrl = (u == 0) ? `CCU_IDX_U1_CTRL : `CCU_IDX_U2_CTRL;
         wire [9:0] idx_flag = (u == 0) ? `CCU_IDX_FLAGS_1 : `CCU_IDX_FLAGS_2;
         wire flag_wbit = (u == 0) ? w_data[`CCU_U1_FLAG_BIT] : w_data[`CCU_U2_FLAG_BIT];
         wire [5:0] ctrl = ctrl_flat[6*u +: 6];
         wire [15:0] hold = hold_flat[16*u +: 16];
         wire [3:0] psc = psc_flat[4*u +: 4];
         wire is_cap = ctrl[3:2] == `CCU_MODE_CLASS_CAPTURE;
         wire is_cmp = ctrl[3:2] == `CCU_MODE_CLASS_COMPARE;
         wire is_pwm = ctrl[3:2] == `CCU_MODE_CLASS_PWM;
         // change accepted once second and third stages agree
         wire settled = sync_b[u] == sync_c[u];
         wire rise = settled && sync_c[u] && !pin_level[u];
         wire fall = settled && !sync_c[u] && pin_level[u];
         wire equal = timer_one_count == hold;
         wire match = is_cmp && equal && !match_prev[u];
         reg cap_evt;

         always @*
         begin
            case (ctrl[1:0])
               `CCU_CAP_FALL:
                  cap_evt = is_cap && fall;
               `CCU_CAP_RISE:
                  cap_evt = is_cap && rise;
               `CCU_CAP_RISE4:
                  cap_evt = is_cap && rise && psc[1:0] == `CCU_PSC_LAST4;
               default:
                  cap_evt = is_cap && rise && psc == `CCU_PSC_LAST16;
            endcase
         end

         always @(posedge aclk)
         begin
            if (!aresetn)
            begin
               sync_a[u] <= 1'b0;
               sync_b[u] <= 1'b0;
               sync_c[u] <= 1'b0;
               pin_level[u] <= 1'b0;
               match_prev[u] <= 1'b0;
               flag[u] <= 1'b0;
               trig[u] <= 1'b0;
               hold_flat[16*u +: 16] <= `CCU_RST_HOLD;
               ctrl_flat[6*u +: 6] <= `CCU_RST_CTRL;
               psc_flat[4*u +: 4] <= 4'h0;
               event_pin_out[u] <= 1'b0;
               event_pin_oe[u] <= 1'b0;
            end
            else
            begin
               // port writes on an output pin reach the pad and so the sampler
               sync_a[u] <= event_pin_in[u];
               sync_b[u] <= sync_a[u];
               sync_c[u] <= sync_b[u];
               if (settled)
                  pin_level[u] <= sync_c[u];
               match_prev[u] <= is_cmp && equal;
               if (wr_byte && aw_idx == idx_ctrl)
                  ctrl_flat[6*u +: 6] <= w_data[5:0];
               // prescaler survives a capture-to-capture switch
               if (!is_cap)
                  psc_flat[4*u +: 4] <= 4'h0;
               else if (rise)
                  psc_flat[4*u +: 4] <= psc + 4'h1;
               // capture wins over a coincident software byte write
               if (cap_evt)
                  hold_flat[16*u +: 16] <= timer_one_count;
               else
               begin
                  if (wr_byte && aw_idx == idx_low)
                     hold_flat[16*u +: 8] <= w_data[7:0];
                  if (wr_byte && aw_idx == idx_high)
                     hold_flat[16*u+8 +: 8] <= w_data[7:0];
               end
               // hardware set beats software clear
               if (cap_evt || match)
                  flag[u] <= 1'b1;
               else if (wr_byte && aw_idx == idx_flag)
                  flag[u] <= flag_wbit;
               trig[u] <= match && ctrl[1:0] == `CCU_CMP_TRIGGER;
               if (ctrl[3:0] == `CCU_MODE_OFF)
                  event_pin_out[u] <= 1'b0;
               else if (match && ctrl[1:0] == `CCU_CMP_SET)
                  event_pin_out[u] <= 1'b1;
               else if (match && ctrl[1:0] == `CCU_CMP_CLEAR)
                  event_pin_out[u] <= 1'b0;
               event_pin_oe[u] <= (is_cmp || is_pwm) && !port_c_direction[u];
            end
         end
      end
   endgenerate

   // ****************************************
   // special event trigger
   // ****************************************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         timer_one_reset <= 1'b0;
         adc_start <= 1'b0;
      end
      else
      begin
         // only a reset request; overflow flag lives in the timer and is not touched
         timer_one_reset <= (trig[0] || trig[1]) && !timer_one_write;
         adc_start <= trig[1] && adc_enabled;
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   reg [7:0] rd_byte;
   reg rd_hit;
   wire [9:0] ar_idx = s_axi_araddr[11:2];

   always @*
   begin
      rd_hit = 1'b1;
      case (ar_idx)
         `CCU_IDX_FLAGS_1:
         begin
            rd_byte = `CCU_RST_BYTE;
            rd_byte[`CCU_U1_FLAG_BIT] = flag[0];
         end
         `CCU_IDX_FLAGS_2:
         begin
            rd_byte = `CCU_RST_BYTE;
            rd_byte[`CCU_U2_FLAG_BIT] = flag[1];
         end
         `CCU_IDX_U1_LOW:
            rd_byte = hold_flat[7:0];
         `CCU_IDX_U1_HIGH:
            rd_byte = hold_flat[15:8];
         `CCU_IDX_U1_CTRL:
            rd_byte = {2'h0, ctrl_flat[5:0]};
         `CCU_IDX_U2_LOW:
            rd_byte = hold_flat[23:16];
         `CCU_IDX_U2_HIGH:
            rd_byte = hold_flat[31:24];
         `CCU_IDX_U2_CTRL:
            rd_byte = {2'h0, ctrl_flat[11:6]};
         `CCU_IDX_ENABLE_1:
            rd_byte = irq_enable_1;
         `CCU_IDX_ENABLE_2:
            rd_byte = {7'h00, irq_enable_2};
         default:
         begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `CCU_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // ccu_top

// *** tb/ccu_partner.sv ***
// timer-1 counter and event pad model
`timescale 1ns/1ps
module ccu_partner
(
   input wire aclk,
   input wire run,
   input wire load,
   input wire [15:0] load_val,
   input wire trig_reset,
   input wire [1:0] level,
   input wire [1:0] pin_out,
   input wire [1:0] pin_oe,
   output logic [15:0] count,
   output wire [1:0] pad
);
   // counts on aclk only, never asynchronously
   always @(posedge aclk)
   begin
      if (load)
         count <= load_val;
      else if (trig_reset)
         count <= 16'h0000;
      else if (run)
         count <= count + 16'h0001;
   end
   // a driven pad follows the unit's latch
   assign pad = (pin_oe & pin_out) | (~pin_oe & level);
endmodule // ccu_partner

// *** tb/ccu_properties.sv ***
// bus and trigger assertions of the block
`timescale 1ns/1ps
module ccu_props
(
   input wire aclk,
   input wire aresetn,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire timer_one_write,
   input wire timer_one_reset,
   input wire adc_start
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_ack;
      s_axi_bvalid && s_axi_bready;
   endsequence
   sequence s_rd_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_rdata_hold: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
      else $error("write answer changed");
   a_write_gap: assert property (s_wr_ack |=> !s_axi_bvalid [*2])
      else $error("write answer too soon");
   a_trig_pulse: assert property (timer_one_reset |=> !timer_one_reset)
      else $error("timer reset not a pulse");
   a_adc_pulse: assert property (adc_start |=> !adc_start)
      else $error("conversion start not a pulse");
   a_adc_trig: assert property (adc_start |-> timer_one_reset || $past(timer_one_write))
      else $error("conversion start without timer reset");
   a_write_wins: assert property (timer_one_write |=> !timer_one_reset)
      else $error("timer reset beat timer write");
endmodule // ccu_props
bind ccu_top ccu_props ccu_props_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .timer_one_write(timer_one_write),
   .timer_one_reset(timer_one_reset), .adc_start(adc_start));

// *** tb/testbench.sv ***
// self-checking bench for the capture/compare block
`timescale 1ns/1ps
`include "ccu_consts.vh"
module testbench;
   logic aclk = 0;
   logic aresetn = 0;
   logic [11:0] awaddr = 0;
   logic [11:0] araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0;
   logic [31:0] rdata;
   logic [1:0] bresp, rresp, pin, pout, poe;
   logic [1:0] dir = 2'h3;
   logic [1:0] lvl = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, trig, adc_go;
   logic adc_en = 0, run = 0, load = 0;
   logic [15:0] count;
   logic [15:0] load_val = 0;
   logic [7:0] modes [3] = '{8'h09, 8'h08, 8'h0a};
   logic [1:0] outs [3] = '{2'h0, 2'h1, 2'h1};
   int err_count = 0, total_checks = 0, cyc = 0;
   int adc_count = 0, adc_mark = 0;
   initial forever #10 aclk = ~aclk;
   ccu_top ccu_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_one_count(count),
      .timer_one_write(load), .adc_enabled(adc_en), .port_c_direction(dir),
      .event_pin_in(pin), .event_pin_out(pout), .event_pin_oe(poe),
      .timer_one_reset(trig), .adc_start(adc_go));
   ccu_partner ccu_partner_inst (.aclk(aclk), .run(run), .load(load), .load_val(load_val),
      .trig_reset(trig), .level(lvl), .pin_out(pout), .pin_oe(poe), .count(count), .pad(pin));
   // ****************************************
   // tasks
   // ****************************************
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (adc_go)
         adc_count <= adc_count + 1;
      if (cyc == 5000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   task chk(input [31:0] s, input [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input [9:0] i, input [7:0] d, input [1:0] er = 2'h0);
      @(posedge aclk);
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 0;
         if (wready)
            wvalid <= 0;
      end
      while (!bvalid);
      // answer left waiting one cycle before it is taken
      bready <= 1;
      @(posedge aclk);
      bready <= 0;
      chk(bresp, er);
   endtask
   task rd(input [9:0] i, input [7:0] e, input [1:0] er = 2'h0);
      @(posedge aclk);
      araddr <= {i, 2'h0};
      arvalid <= 1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 0;
      end
      while (!rvalid);
      // answer left waiting one cycle before it is taken
      rready <= 1;
      @(posedge aclk);
      rready <= 0;
      chk(rdata, {24'h0, e});
      chk(rresp, er);
   endtask
   task pulse(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         lvl[0] <= 1;
         repeat (6) @(posedge aclk);
         lvl[0] <= 0;
         repeat (6) @(posedge aclk);
      end
   endtask
   task tl(input [15:0] c);
      @(posedge aclk);
      load_val <= c;
      load <= 1;
      @(posedge aclk);
      load <= 0;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      rd(`CCU_IDX_FLAGS_1, 8'h00);
      rd(`CCU_IDX_U1_CTRL, 8'h00);
      wr(`CCU_IDX_ENABLE_1, 8'ha5);
      rd(`CCU_IDX_ENABLE_1, 8'ha5);
      rd(10'h001, 8'h00, `CCU_RESP_SLVERR);
      wr(10'h001, 8'h11, `CCU_RESP_SLVERR);
      wr(`CCU_IDX_U1_CTRL, 8'hff);
      rd(`CCU_IDX_U1_CTRL, 8'h3f);
      $display("test done: registers");
      wr(`CCU_IDX_U1_CTRL, 8'h05);
      tl(16'hbeef);
      wr(`CCU_IDX_FLAGS_1, 8'h00);
      pulse(1);
      rd(`CCU_IDX_U1_LOW, 8'hef);
      rd(`CCU_IDX_U1_HIGH, 8'hbe);
      tl(16'h5a3c);
      pulse(1);
      rd(`CCU_IDX_U1_LOW, 8'h3c);
      rd(`CCU_IDX_FLAGS_1, 8'h04);
      wr(`CCU_IDX_FLAGS_1, 8'h00);
      rd(`CCU_IDX_FLAGS_1, 8'h00);
      wr(`CCU_IDX_U1_CTRL, 8'h04);
      tl(16'h0c71);
      lvl[0] <= 1;
      repeat (8) @(posedge aclk);
      rd(`CCU_IDX_FLAGS_1, 8'h00);
      lvl[0] <= 0;
      repeat (8) @(posedge aclk);
      rd(`CCU_IDX_U1_LOW, 8'h71);
      for (int k = 0; k < 2; k++)
      begin
         wr(`CCU_IDX_U1_CTRL, 8'h00);
         wr(`CCU_IDX_U1_CTRL, 8'h06 + k[7:0]);
         wr(`CCU_IDX_FLAGS_1, 8'h00);
         pulse(k ? 15 : 3);
         rd(`CCU_IDX_FLAGS_1, 8'h00);
         pulse(1);
         rd(`CCU_IDX_FLAGS_1, 8'h04);
      end
      $display("test done: capture");
      dir <= 2'h0;
      wr(`CCU_IDX_U1_LOW, 8'h20);
      wr(`CCU_IDX_U1_HIGH, 8'h00);
      for (int k = 0; k < 3; k++)
      begin
         run <= 0;
         tl(16'h0000);
         wr(`CCU_IDX_U1_CTRL, modes[k]);
         wr(`CCU_IDX_FLAGS_1, 8'h00);
         run <= 1;
         repeat (60) @(posedge aclk);
         chk(pout[0], outs[k][0]);
         chk(poe[0], 1'b1);
         rd(`CCU_IDX_FLAGS_1, 8'h04);
      end
      wr(`CCU_IDX_U1_CTRL, 8'h00);
      chk(pout, 2'h0);
      adc_en <= 1;
      run <= 0;
      tl(16'h0000);
      wr(`CCU_IDX_U2_LOW, 8'h10);
      wr(`CCU_IDX_U2_CTRL, 8'h0b);
      wr(`CCU_IDX_FLAGS_2, 8'h00);
      run <= 1;
      repeat (60) @(posedge aclk);
      chk(adc_count != 0, 1'b1);
      chk(count < 16'h0014, 1'b1);
      rd(`CCU_IDX_FLAGS_2, 8'h01);
      $display("test done: compare");
      run <= 0;
      wr(`CCU_IDX_U2_CTRL, 8'h00);
      repeat (4) @(posedge aclk);
      adc_mark = adc_count;
      tl(16'h0000);
      wr(`CCU_IDX_U1_CTRL, 8'h0b);
      wr(`CCU_IDX_FLAGS_1, 8'h00);
      run <= 1;
      // timer write lands in the cycle the unit 1 reset pulse is formed
      repeat (32) @(posedge aclk);
      tl(16'h0100);
      repeat (2) @(posedge aclk);
      chk(count, 16'h0101);
      tl(16'h0000);
      repeat (60) @(posedge aclk);
      chk(count < 16'h0023, 1'b1);
      chk(adc_count == adc_mark, 1'b1);
      rd(`CCU_IDX_FLAGS_1, 8'h04);
      $display("test done: trigger");
      report_and_stop();
   end
endmodule // testbench
